// file: rtl/dcf_consts.svh
// constants for the deep buffer with programmable level flags
// assumes one clock; control pins other than the clock enable are active low, and all but the reset are synchronous to it
// Notes on behaviour
// [R1] full init clear zeroes both pointers and the output register
// [R2] full init clear latches timing mode, default offset and programming method
// [R3] partial clear zeroes both pointers and the output register
// [R4] partial clear keeps mode, method and both offset values
// [R5] replay sets only the read pointer to zero; all else kept; code also clears the fall-through valid and latency state
// [R6] during replay empty flag goes low, or valid flag high in fall-through
// [R7] fall-through/serial pin chooses timing mode during full init clear
// [R8] after full init clear that pin is the serial offset input
// [R9] enabled write stores the word, or the offsets when offset access selected; code stores offsets only with parallel method
// [R10] enabled serial load shifts exactly one bit into the offsets
// [R11] enabled read outputs next word, or offsets when offset access selected
// [R12] output bus driven only while output enable asserted
// [R13] offset select during full init picks default 127 or 1023 and method
// [R14] after full init offset select redirects writes and reads to offsets; code redirects writes only with parallel method
// [R15] full flag in standard mode, space available flag in fall-through
// [R16] empty flag in standard mode, data valid flag in fall-through
// [R17] near full low when count exceeds capacity minus full offset
// [R18] near empty low when count below empty offset
// [R19] half level flag shows count above or below half capacity
// [R20] write and read data buses are 18 bits wide
// [R21] default 127 pairs with parallel, 1023 with serial programming
// [R22] fall-through first word appears after three clocks without read
// [R23] standard mode first word needs an explicit enabled read
// [R24] resets, replay, enables, offset select and output enable are active low
// [R25] writes when full and reads when empty are ignored; writes when full wait in the 8-word skid fifo until it fills
`ifndef DCF_CONSTS_SVH
`define DCF_CONSTS_SVH
`define DCF_WIDTH 18
`define DCF_DEPTH 8192
`define DCF_AW 13
`define DCF_CW 14
`define DCF_HALF 14'h1000
`define DCF_OFS_DEF_LO 13'h007f
`define DCF_OFS_DEF_HI 13'h03ff
`define DCF_FALLTHROUGH_MODE_LAT 2'h2
`define DCF_SKID_DEPTH 8
`define DCF_Q_RESET 18'h00000
`endif

// file: rtl/dcf_pkg.sv
// types shared by the buffer top and its bench
// assumes dcf_consts.svh is included before use
`include "dcf_consts.svh"
package dcf_pkg;
    typedef struct packed {
        logic fallthrough_mode;
        logic serial_method;
    } dcf_setup_t;
    typedef struct packed {
        logic full_space_flag;
        logic empty_valid_flag;
        logic near_full_flag;
        logic near_empty_flag;
        logic half_level_flag;
    } dcf_flags_t;
endpackage

// file: rtl/dcf_buffer.sv
// deep buffer with level flags, an 8-word write skid fifo and offset registers
// assumes writer and reader logic run on i_mclk; control pins other than i_clk_en are active low
`timescale 1ns/10ps
`default_nettype none
`include "dcf_consts.svh"

module dcf_skid_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic i_flush,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_reg;
    logic [AW:0] rd_reg;
    logic push;
    logic pop;

    // honest full and empty from extended pointers
    assign o_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
    assign o_valid = wr_reg != rd_reg;
    assign o_data = mem_reg[rd_reg[AW-1:0]];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    // pointers
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else if (i_clk_en) begin
            if (i_flush) begin
                wr_reg <= '0;
                rd_reg <= '0;
            end else begin
                if (push) begin
                    wr_reg <= wr_reg + 1'b1;
                end
                if (pop) begin
                    rd_reg <= rd_reg + 1'b1;
                end
            end
        end
    end

    // storage, no reset needed on data
    always_ff @(posedge i_mclk) begin
        if (i_clk_en && push && !i_flush) begin
            mem_reg[wr_reg[AW-1:0]] <= i_data;
        end
    end
endmodule

module dcf_buffer (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic i_full_init_clear_n,
    input wire logic i_partial_clear_n,
    input wire logic i_replay_request_n,
    input wire logic i_fallthrough_select_serial_in,
    input wire logic i_write_enable_n,
    input wire logic i_bitwise_load_enable_n,
    input wire logic i_offset_access_select_n,
    input wire logic i_read_enable_n,
    input wire logic i_output_enable_n,
    input wire logic [`DCF_WIDTH-1:0] i_write_data_in,
    output logic o_write_ready,
    output logic [`DCF_WIDTH-1:0] o_read_data_out,
    output logic o_read_data_oe,
    output dcf_pkg::dcf_flags_t o_flags,
    output dcf_pkg::dcf_setup_t o_setup
);
    // active-low pins turned round once
    // [R24] active low controls
    logic full_init;
    logic part_clr;
    logic replay;
    logic wr_en;
    logic ser_en;
    logic ofs_sel;
    logic rd_en;
    assign full_init = !i_full_init_clear_n;
    assign part_clr = !i_partial_clear_n;
    assign replay = !i_replay_request_n;
    assign wr_en = !i_write_enable_n;
    assign ser_en = !i_bitwise_load_enable_n;
    assign ofs_sel = !i_offset_access_select_n;
    assign rd_en = !i_read_enable_n;

    logic clear;
    assign clear = full_init || part_clr;

    dcf_pkg::dcf_setup_t setup_reg;
    logic [`DCF_AW-1:0] ofs_empty_reg;
    logic [`DCF_AW-1:0] ofs_full_reg;
    logic wr_sel_reg;
    logic rd_sel_reg;
    logic [`DCF_WIDTH-1:0] mem_reg [`DCF_DEPTH];
    logic [`DCF_CW-1:0] wp_reg;
    logic [`DCF_CW-1:0] rp_reg;
    logic [`DCF_WIDTH-1:0] q_reg;
    logic valid_reg;
    logic [1:0] lat_reg;
    logic replay_reg;

    logic [`DCF_CW-1:0] count;
    logic mem_full;
    logic mem_empty;
    assign count = wp_reg - rp_reg;
    assign mem_full = count == `DCF_CW'(`DCF_DEPTH);
    assign mem_empty = count == '0;

    // write path through skid fifo; offset cycles bypass it
    logic skid_in_valid;
    logic skid_in_ready;
    logic skid_out_valid;
    logic skid_out_ready;
    logic [`DCF_WIDTH-1:0] skid_data;
    logic mem_push;
    // [R9] data or offsets
    assign skid_in_valid = wr_en && !ofs_sel && !clear;
    // [R25] full write held off
    assign skid_out_ready = !mem_full && !clear;
    assign mem_push = skid_out_valid && skid_out_ready;
    assign o_write_ready = skid_in_ready && !clear;

    dcf_skid_fifo #(
        .WIDTH(`DCF_WIDTH),
        .DEPTH(`DCF_SKID_DEPTH)
    ) u_skid (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en),
        .i_flush(clear),
        .i_valid(skid_in_valid),
        .o_ready(skid_in_ready),
        .i_data(i_write_data_in),
        .o_valid(skid_out_valid),
        .i_ready(skid_out_ready),
        .o_data(skid_data)
    );

    // straps caught while full init clear is held
    // [R2] latch settings
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            setup_reg <= '0;
        end else if (i_clk_en && full_init) begin
            // [R7] mode from shared pin
            setup_reg.fallthrough_mode <= i_fallthrough_select_serial_in;
            // [R13] method from offset select
            setup_reg.serial_method <= i_offset_access_select_n;
        end
    end

    // offset registers; partial clear leaves them alone
    // [R4] offsets kept on partial clear
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ofs_empty_reg <= `DCF_OFS_DEF_LO;
            ofs_full_reg <= `DCF_OFS_DEF_LO;
            wr_sel_reg <= 1'b0;
        end else if (i_clk_en) begin
            if (full_init) begin
                // [R21] default pairs with method
                ofs_empty_reg <= i_offset_access_select_n ? `DCF_OFS_DEF_HI : `DCF_OFS_DEF_LO;
                ofs_full_reg <= i_offset_access_select_n ? `DCF_OFS_DEF_HI : `DCF_OFS_DEF_LO;
                wr_sel_reg <= 1'b0;
            end else if (part_clr) begin
                wr_sel_reg <= 1'b0;
            end else if (ofs_sel && ser_en && setup_reg.serial_method) begin
                // [R8] pin is serial data now
                // [R10] one bit per edge
                {ofs_full_reg, ofs_empty_reg} <= {i_fallthrough_select_serial_in,
                    ofs_full_reg, ofs_empty_reg[`DCF_AW-1:1]};
            end else if (ofs_sel && wr_en && !setup_reg.serial_method) begin
                // [R14] write goes to offsets
                if (wr_sel_reg) begin
                    ofs_full_reg <= i_write_data_in[`DCF_AW-1:0];
                end else begin
                    ofs_empty_reg <= i_write_data_in[`DCF_AW-1:0];
                end
                wr_sel_reg <= !wr_sel_reg;
            end
        end
    end

    // main storage
    always_ff @(posedge i_mclk) begin
        if (i_clk_en && mem_push) begin
            mem_reg[wp_reg[`DCF_AW-1:0]] <= skid_data;
        end
    end

    // read side decisions
    logic std_read;
    logic ft_take;
    logic ft_load;
    logic ofs_read;
    // [R25] empty read ignored
    assign std_read = !setup_reg.fallthrough_mode && rd_en && !ofs_sel && !mem_empty;
    assign ft_take = setup_reg.fallthrough_mode && rd_en && !ofs_sel && valid_reg;
    // [R22] first word falls through after latency
    assign ft_load = setup_reg.fallthrough_mode && !mem_empty
        && ((!valid_reg && lat_reg == `DCF_FALLTHROUGH_MODE_LAT) || ft_take);
    assign ofs_read = rd_en && ofs_sel;

    // pointers
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else if (i_clk_en) begin
            if (clear) begin
                // [R1] [R3] pointers to zero
                wp_reg <= '0;
                rp_reg <= '0;
            end else begin
                if (mem_push) begin
                    wp_reg <= wp_reg + 1'b1;
                end
                if (replay) begin
                    // [R5] only read pointer rewinds
                    rp_reg <= '0;
                end else if (std_read || ft_load) begin
                    rp_reg <= rp_reg + 1'b1;
                end
            end
        end
    end

    // output register and fall-through valid
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q_reg <= `DCF_Q_RESET;
            valid_reg <= 1'b0;
            lat_reg <= '0;
            rd_sel_reg <= 1'b0;
        end else if (i_clk_en) begin
            if (clear) begin
                // [R1] [R3] output register zeroed
                q_reg <= `DCF_Q_RESET;
                valid_reg <= 1'b0;
                lat_reg <= '0;
                rd_sel_reg <= 1'b0;
            end else if (replay) begin
                valid_reg <= 1'b0;
                lat_reg <= '0;
            end else if (ofs_read) begin
                // [R11] offsets read back alternately
                q_reg <= `DCF_WIDTH'(rd_sel_reg ? ofs_full_reg : ofs_empty_reg);
                rd_sel_reg <= !rd_sel_reg;
            end else if (std_read || ft_load) begin
                // [R11] [R20] next word out
                // [R23] standard needs a read
                q_reg <= mem_reg[rp_reg[`DCF_AW-1:0]];
                valid_reg <= 1'b1;
                lat_reg <= '0;
            end else begin
                if (ft_take) begin
                    valid_reg <= 1'b0;
                end
                // latency counts only while a word waits
                if (!valid_reg && !mem_empty && lat_reg != `DCF_FALLTHROUGH_MODE_LAT) begin
                    lat_reg <= lat_reg + 1'b1;
                end else if (mem_empty) begin
                    lat_reg <= '0;
                end
            end
        end
    end

    // replay marker, one cycle after the request
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            replay_reg <= 1'b0;
        end else if (i_clk_en) begin
            replay_reg <= replay && !clear;
        end
    end

    // level flags, all active low, registered for clean outputs
    logic [`DCF_CW-1:0] full_mark;
    assign full_mark = `DCF_CW'(`DCF_DEPTH) - {1'b0, ofs_full_reg};
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_flags <= '1;
        end else if (i_clk_en) begin
            // [R15] full or space available
            o_flags.full_space_flag <= setup_reg.fallthrough_mode ? mem_full : !mem_full;
            // [R6] [R16] empty or valid, forced during replay
            if (replay || replay_reg) begin
                o_flags.empty_valid_flag <= setup_reg.fallthrough_mode;
            end else begin
                o_flags.empty_valid_flag <= setup_reg.fallthrough_mode ? !valid_reg : !mem_empty;
            end
            // [R17] near full
            o_flags.near_full_flag <= !(count > full_mark);
            // [R18] near empty
            o_flags.near_empty_flag <= !(count < {1'b0, ofs_empty_reg});
            // [R19] half level
            o_flags.half_level_flag <= !(count > `DCF_HALF);
        end
    end

    assign o_setup = setup_reg;
    assign o_read_data_out = q_reg;
    // [R12] drive only when enabled
    assign o_read_data_oe = !i_output_enable_n;
endmodule
`default_nettype wire

// file: verif/dcf_buffer_asserts.sv
// port checker for the level-flag buffer
// assumes it is bound to dcf_buffer and sees only its ports
`timescale 1ns/10ps
`default_nettype none
`include "dcf_consts.svh"
module dcf_buffer_asserts (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic i_full_init_clear_n,
    input wire logic i_partial_clear_n,
    input wire logic i_replay_request_n,
    input wire logic i_fallthrough_select_serial_in,
    input wire logic i_offset_access_select_n,
    input wire logic i_read_enable_n,
    input wire logic i_output_enable_n,
    input wire logic o_read_data_oe,
    input wire logic [`DCF_WIDTH-1:0] o_read_data_out,
    input wire dcf_pkg::dcf_flags_t o_flags,
    input wire dcf_pkg::dcf_setup_t o_setup
);
    logic quiet;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    // an enabled edge with no clear or replay in it
    assign quiet = i_clk_en & i_full_init_clear_n & i_partial_clear_n & i_replay_request_n;
    // control effects seen at the ports
    out_enable_a: assert property (o_read_data_oe == !i_output_enable_n)
        else $error("bus enable does not follow its pin");
    init_zero_a: assert property (!i_full_init_clear_n && i_clk_en |=>
        o_read_data_out == `DCF_Q_RESET) else $error("output not zero after full clear");
    part_zero_a: assert property (!i_partial_clear_n && i_clk_en |=>
        o_read_data_out == `DCF_Q_RESET) else $error("output not zero after partial clear");
    strap_latch_a: assert property (!i_full_init_clear_n && i_clk_en |=> o_setup ==
        {$past(i_fallthrough_select_serial_in), $past(i_offset_access_select_n)})
        else $error("straps not latched");
    setup_keep_a: assert property (i_full_init_clear_n && i_clk_en &&
        !(i_partial_clear_n && i_replay_request_n) |=> $stable(o_setup))
        else $error("setup lost on clear or replay");
    replay_flag_a: assert property (!i_replay_request_n && i_full_init_clear_n &&
        i_partial_clear_n && i_clk_en |=> o_flags.empty_valid_flag == o_setup.fallthrough_mode)
        else $error("replay flag level wrong");
    // standard timing never moves the output without a read
    q_hold_a: assert property (quiet && i_read_enable_n && !o_setup.fallthrough_mode |=>
        $stable(o_read_data_out)) else $error("output moved without read");
    init_flags_a: assert property (!i_full_init_clear_n && i_clk_en ##1 quiet |=>
        o_flags.empty_valid_flag == o_setup.fallthrough_mode &&
        o_flags.full_space_flag == !o_setup.fallthrough_mode) else $error("flags wrong after init");
    cover property (!o_flags.full_space_flag && !o_setup.fallthrough_mode);
    cover property (!i_replay_request_n && quiet);
    cover property (o_setup.fallthrough_mode && !o_flags.empty_valid_flag);
endmodule
`default_nettype wire

// file: verif/dcf_reader_model.sv
// reader logic on the far side: pulls a given number of words
// assumes standard timing; waits for the lagging flag between reads
`timescale 1ns/10ps
`default_nettype none
`include "dcf_consts.svh"
module dcf_reader_model (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_stall,
    input wire logic [15:0] i_want,
    input wire logic i_empty_valid_flag,
    output logic o_read_enable_n,
    output logic o_got,
    output logic [15:0] o_count
);
    logic [1:0] step_reg;
    // three clocks a word so the flag is current when looked at
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            step_reg <= 2'h0;
            o_read_enable_n <= 1'h1;
            o_got <= 1'h0;
            o_count <= 16'h0;
        end else begin
            o_got <= 1'h0;
            case (step_reg)
                2'h0: if (o_count < i_want && i_empty_valid_flag && !i_stall) begin
                    o_read_enable_n <= 1'h0;
                    step_reg <= 2'h1;
                end
                2'h1: begin
                    o_read_enable_n <= 1'h1;
                    step_reg <= 2'h2;
                end
                default: begin
                    o_got <= 1'h1;
                    o_count <= o_count + 16'h1;
                    step_reg <= 2'h0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: verif/dcf_buffer_tb.sv
// self-checking bench for the level-flag buffer
// assumes the reader model drains words; bench drives all other pins
`timescale 1ns/10ps
`default_nettype none
`include "dcf_consts.svh"
module dcf_buffer_tb;
    logic mclk, reset_n, init_n, part_n, replay_n, ft_si, wr_n, bit_n, sel_n, rd_n, oe_n;
    logic stall, ready, oe, mdl_rd_n, got, took;
    logic [`DCF_WIDTH-1:0] din, q, keep[10];
    logic [15:0] want, got_cnt;
    logic [25:0] bits;
    dcf_pkg::dcf_flags_t flags;
    dcf_pkg::dcf_setup_t setup;
    logic [`DCF_WIDTH-1:0] expq[$];
    int fails, compares, cycles;
    dcf_buffer i_dcf_buffer (.i_mclk(mclk), .i_reset_n(reset_n), .i_clk_en(1'h1),
        .i_full_init_clear_n(init_n), .i_partial_clear_n(part_n), .i_replay_request_n(replay_n),
        .i_fallthrough_select_serial_in(ft_si), .i_write_enable_n(wr_n),
        .i_bitwise_load_enable_n(bit_n), .i_offset_access_select_n(sel_n),
        .i_read_enable_n(rd_n & mdl_rd_n), .i_output_enable_n(oe_n), .i_write_data_in(din),
        .o_write_ready(ready), .o_read_data_out(q), .o_read_data_oe(oe), .o_flags(flags),
        .o_setup(setup));
    dcf_reader_model i_dcf_reader_model (.i_mclk(mclk), .i_reset_n(reset_n), .i_stall(stall),
        .i_want(want), .i_empty_valid_flag(flags.empty_valid_flag), .o_read_enable_n(mdl_rd_n),
        .o_got(got), .o_count(got_cnt));
    task automatic chk(input string nm, input logic [25:0] e, input logic [25:0] g);
        compares++;
        if (e !== g) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [`DCF_WIDTH-1:0] d, input logic s);
        @(posedge mclk);
        wr_n <= 1'h0;
        sel_n <= s;
        din <= d;
        @(posedge mclk);
        wr_n <= 1'h1;
        sel_n <= 1'h1;
    endtask
    task automatic rd_ofs(input logic [12:0] e);
        @(posedge mclk);
        rd_n <= 1'h0;
        sel_n <= 1'h0;
        @(posedge mclk);
        rd_n <= 1'h1;
        sel_n <= 1'h1;
        @(negedge mclk);
        chk("offset", {13'h0000, e}, q);
    endtask
    task automatic init(input logic ft, input logic s, input logic [4:0] ef);
        @(posedge mclk);
        init_n <= 1'h0;
        ft_si <= ft;
        sel_n <= s;
        @(posedge mclk);
        init_n <= 1'h1;
        sel_n <= 1'h1;
        tick(2);
        @(negedge mclk);
        chk("setup", {ft, s}, setup);
        chk("flags", ef, flags);
        chk("output", `DCF_Q_RESET, q);
    endtask
    task automatic drain(input int n);
        @(posedge mclk);
        want <= want + n[15:0];
        // let the new target settle before the loop compares against it
        @(posedge mclk);
        for (int i = 0; i < 40000 && got_cnt !== want; i++) @(posedge mclk);
        tick(3);
        chk("left", 0, expq.size());
    endtask
    // clock source
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    // each word the reader takes must be the oldest still owed
    always @(posedge mclk) begin
        stall <= ($urandom_range(3) == 0);
        cycles++;
        if (got === 1'h1) chk("word", expq.pop_front(), q);
        if (cycles == 60000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        {init_n, part_n, replay_n, wr_n, bit_n, sel_n, rd_n, oe_n} = 8'hff;
        {reset_n, ft_si, stall, took} = 4'h0;
        din = `DCF_Q_RESET;
        want = 16'h0;
        void'($urandom(14904));
        tick(12);
        reset_n <= 1'h1;
        init(1'h0, 1'h0, 5'h15);
        wr(18'h00005, 1'h0);
        wr(18'h00003, 1'h0);
        rd_ofs(13'h0005);
        rd_ofs(13'h0003);
        // count 4 is below the empty offset of 5, count 5 is not
        for (int i = 0; i < 10; i++) begin
            keep[i] = `DCF_WIDTH'($urandom);
            expq.push_back(keep[i]);
            wr(keep[i], 1'h1);
            if (i == 3 || i == 4) begin
                tick(3);
                // look between edges, once the flag has settled
                @(negedge mclk);
                chk("near empty", i == 4, flags.near_empty_flag);
            end
        end
        tick(3);
        @(negedge mclk);
        chk("empty", 1'h1, flags.empty_valid_flag);
        drain(10);
        @(posedge mclk) replay_n <= 1'h0;
        @(posedge mclk) replay_n <= 1'h1;
        for (int i = 0; i < 10; i++) expq.push_back(keep[i]);
        drain(10);
        @(posedge mclk) part_n <= 1'h0;
        @(posedge mclk) part_n <= 1'h1;
        tick(3);
        @(negedge mclk);
        chk("cleared", {`DCF_Q_RESET, 5'h15, 2'h0}, {q, flags, setup});
        rd_ofs(13'h0005);
        @(posedge mclk) oe_n <= 1'h0;
        @(negedge mclk) chk("drive", 1'h1, oe);
        @(posedge mclk) oe_n <= 1'h1;
        @(negedge mclk) chk("drive", 1'h0, oe);
        // write 8300 times, past the refusal; words taken only while ready was high
        repeat (8300) begin
            @(negedge mclk) took = (wr_n === 1'h0) && (ready === 1'h1);
            @(posedge mclk);
            if (took) expq.push_back(din);
            wr_n <= 1'h0;
            din <= `DCF_WIDTH'($urandom);
        end
        @(posedge mclk) wr_n <= 1'h1;
        tick(3);
        chk("stored", 8200, expq.size());
        chk("full flags", {5'h0a, 1'h0}, {flags, ready});
        drain(8200);
        chk("drained", 5'h15, flags);
        init(1'h1, 1'h1, 5'h0d);
        bits = {13'h0004, 13'h0002};
        for (int i = 0; i < 26; i++) begin
            @(posedge mclk);
            {bit_n, sel_n, ft_si} <= {2'h0, bits[i]};
        end
        @(posedge mclk) {bit_n, sel_n} <= 2'h3;
        rd_ofs(13'h0002);
        rd_ofs(13'h0004);
        wr(18'h2a5c3, 1'h1);
        tick(6);
        @(negedge mclk) chk("fall through", {18'h2a5c3, 1'h0}, {q, flags.empty_valid_flag});
        give_verdict();
    end
endmodule
bind dcf_buffer dcf_buffer_asserts i_dcf_buffer_asserts (.i_mclk, .i_reset_n, .i_clk_en,
    .i_full_init_clear_n, .i_partial_clear_n, .i_replay_request_n,
    .i_fallthrough_select_serial_in, .i_offset_access_select_n, .i_read_enable_n,
    .i_output_enable_n, .o_read_data_oe, .o_read_data_out, .o_flags, .o_setup);
`default_nettype wire
